// [hdl/fcs_pkg.sv]
// Purpose: shared constants and types for the flash command sequencer
// Assumes: 32-bit word write bus from the processor, single clock
// Notes: command codes compare against the low data byte only
package fcs_pkg;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_BLOCK = 8'h30;
  localparam logic [7:0] CODE_PBPROG = 8'h9A;
  localparam logic [7:0] CODE_PBERASE = 8'h6A;
  localparam logic [7:0] CODE_IDREAD = 8'h90;
  localparam logic [7:0] CODE_IDSEL = 8'h00;
  localparam logic [7:0] CODE_READ = 8'hF0;
  // unlock addresses: bits [15:9] of the command cycles
  localparam logic [6:0] ADDR_55 = 7'h55;
  localparam logic [6:0] ADDR_AA = 7'h2A;
  localparam int ADDR_CMD_LSB = 9;
  localparam int ADDR_CMD_MSB = 15;
  localparam int ID_SEL_LSB = 12;
  localparam int ID_SEL_MSB = 13;
  localparam int PB_SEL_LSB = 7;
  localparam int PB_SEL_MSB = 8;
  localparam int PB_ZERO_LSB = 9;
  localparam int PB_ZERO_MSB = 14;
  localparam logic [1:0] ID_SEL_MAKER = 2'h0;
  localparam logic [1:0] ID_SEL_DEVICE = 2'h1;
  localparam logic [1:0] ID_SEL_MACRO = 2'h3;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam int NUM_BLOCKS = 4;
  localparam logic [3:0] PROT_RESET = 4'h0;

  typedef enum logic [3:0] {
    FCS_READ = 4'h0,
    FCS_C1 = 4'h1,
    FCS_C2 = 4'h2,
    FCS_C3 = 4'h3,
    FCS_C4 = 4'h4,
    FCS_C5 = 4'h5,
    FCS_C6 = 4'h6,
    FCS_ID = 4'h7,
    FCS_PAGE = 4'h8,
    FCS_BUSY = 4'h9
  } fcs_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PAGE = 3'h1,
    OP_CHIP = 3'h2,
    OP_BLOCK = 3'h3,
    OP_PBPROG = 3'h4,
    OP_PBERASE = 3'h5,
    OP_SECERASE = 3'h6
  } fcs_op_t;
endpackage : fcs_pkg

// [hdl/fcs_op_if.sv]
// Purpose: carries one automatic operation from sequencer to timer
// Assumes: start is a one-cycle pulse, done a one-cycle pulse
// Notes: none
`timescale 1ns/1ps
interface fcs_op_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface : fcs_op_if

// [hdl/fcs_op_timer.sv]
// Purpose: times an automatic operation and reports its end
// Assumes: op_cycles at least 1
// Notes: a start while running is ignored
`timescale 1ns/1ps
module fcs_op_timer #(
  parameter int OP_CYCLES = 16
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, high
  fcs_op_if.tmr op // start and done
);
  typedef struct packed {
    logic run;
    logic [15:0] cnt;
    logic done;
  } fcs_tmr_t;
  fcs_tmr_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.run && op.start) begin
      st_next.run = 1'b1;
      st_next.cnt = 16'(OP_CYCLES - 1);
    end else if (st_reg.run) begin
      if (st_reg.cnt == 16'h0000) begin
        st_next.run = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign op.done = st_reg.done;
endmodule : fcs_op_timer

// [hdl/fcs_sequencer.sv]
// Purpose: decodes word write cycles into flash commands, models the array
// Assumes: writes come one per cycle from the same clock domain
// Notes:
`timescale 1ns/1ps
module fcs_sequencer #(
  parameter int PAGE_WORDS = 4,
  parameter int BLOCK_PAGES = 2,
  parameter int OP_CYCLES = 16,
  parameter logic [7:0] MAKER_CODE = 8'h11, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h22, // arbitrary value
  parameter logic [7:0] MACRO_CODE = 8'h44 // arbitrary value
) (
  input wire logic clock, // system clock, 10 MHz
  input wire logic sys_rst, // async reset, high
  input wire logic wr_en, // one-cycle word write strobe
  input wire logic [31:0] wr_addr, // byte address of the write
  input wire logic [31:0] wr_data, // write data
  input wire logic rd_en, // read request
  input wire logic [31:0] rd_addr, // byte address of the read
  output logic [31:0] rd_data, // read data, valid cycle after rd_en
  input wire logic security_enable_bit, // secured when set with all protects
  output logic ready_busy_flag, // 1 ready, 0 automatic op running
  output logic [3:0] protect_bits // per-block protect state
);
  function automatic int NUM_WORDS();
    return PAGE_WORDS * BLOCK_PAGES * fcs_pkg::NUM_BLOCKS;
  endfunction : NUM_WORDS

  localparam int WORDS = NUM_WORDS();
  localparam int WAW = $clog2(WORDS);
  localparam int PWW = $clog2(PAGE_WORDS);
  localparam int BSH = $clog2(PAGE_WORDS * BLOCK_PAGES);

  function automatic logic [1:0] blk_of(input logic [31:0] a);
    logic [WAW-1:0] w;
    w = a[WAW+1:2];
    return 2'(w >> BSH);
  endfunction : blk_of

  function automatic logic is_unlock(input logic [31:0] a, input logic [6:0] v);
    return a[fcs_pkg::ADDR_CMD_MSB:fcs_pkg::ADDR_CMD_LSB] == v;
  endfunction : is_unlock

  typedef struct packed {
    fcs_pkg::fcs_state_t state;
    fcs_pkg::fcs_op_t op;
    logic [7:0] third; // code of the third cycle
    logic [1:0] id_sel;
    logic [1:0] blk;
    logic [PWW-1:0] wcnt;
    logic [WAW-1:0] pbase;
    logic [3:0] prot;
    logic [31:0] rdata;
  } fcs_seq_t;
  fcs_seq_t st_reg, st_next;

  logic [31:0] mem [WORDS];
  fcs_op_if opif();
  logic [7:0] d;
  logic secured;

  fcs_op_timer #(.OP_CYCLES(OP_CYCLES)) u_tmr (
    .clock(clock),
    .sys_rst(sys_rst),
    .op(opif.tmr)
  );

  assign d = wr_data[7:0];
  assign secured = security_enable_bit && (st_reg.prot == 4'hF);

  always_comb begin
    st_next = st_reg;
    opif.start = 1'b0;
    if (st_reg.state == fcs_pkg::FCS_BUSY) begin
      // writes are dropped here
      if (opif.done) begin
        st_next.state = fcs_pkg::FCS_READ;
        st_next.op = fcs_pkg::OP_NONE;
        if (st_reg.op == fcs_pkg::OP_PBPROG) begin
          st_next.prot[st_reg.blk] = 1'b1;
        end
        if (st_reg.op == fcs_pkg::OP_PBERASE || st_reg.op == fcs_pkg::OP_SECERASE) begin
          st_next.prot = fcs_pkg::PROT_RESET;
        end
      end
    end else if (wr_en && d == fcs_pkg::CODE_READ && st_reg.state != fcs_pkg::FCS_PAGE) begin
      st_next.state = fcs_pkg::FCS_READ;
    end else if (wr_en) begin
      st_next.state = fcs_pkg::FCS_READ; // default: bad order abandons
      unique case (st_reg.state)
        fcs_pkg::FCS_READ, fcs_pkg::FCS_ID: begin
          if (st_reg.state == fcs_pkg::FCS_ID && d == fcs_pkg::CODE_IDSEL) begin
            st_next.state = fcs_pkg::FCS_ID;
            st_next.id_sel = wr_addr[fcs_pkg::ID_SEL_MSB:fcs_pkg::ID_SEL_LSB];
          end else if (st_reg.state == fcs_pkg::FCS_READ && d == fcs_pkg::CODE_UNLOCK1
                       && is_unlock(wr_addr, fcs_pkg::ADDR_55)) begin
            st_next.state = fcs_pkg::FCS_C1;
          end else if (st_reg.state == fcs_pkg::FCS_ID) begin
            st_next.state = fcs_pkg::FCS_ID;
          end
        end
        fcs_pkg::FCS_C1: begin
          if (d == fcs_pkg::CODE_UNLOCK2 && is_unlock(wr_addr, fcs_pkg::ADDR_AA)) begin
            st_next.state = fcs_pkg::FCS_C2;
          end
        end
        fcs_pkg::FCS_C2: begin
          st_next.third = d;
          if (is_unlock(wr_addr, fcs_pkg::ADDR_55)) begin
            unique case (d)
              fcs_pkg::CODE_PROG: begin
                st_next.state = fcs_pkg::FCS_PAGE;
                st_next.wcnt = '0;
              end
              fcs_pkg::CODE_IDREAD: st_next.state = fcs_pkg::FCS_C3;
              fcs_pkg::CODE_ERASE, fcs_pkg::CODE_PBPROG, fcs_pkg::CODE_PBERASE:
                st_next.state = fcs_pkg::FCS_C3;
              default: st_next.state = fcs_pkg::FCS_READ;
            endcase
          end
        end
        fcs_pkg::FCS_C3: begin
          if (st_reg.third == fcs_pkg::CODE_IDREAD) begin
            if (d == fcs_pkg::CODE_IDSEL) begin
              st_next.state = fcs_pkg::FCS_ID;
              st_next.id_sel = wr_addr[fcs_pkg::ID_SEL_MSB:fcs_pkg::ID_SEL_LSB];
            end
          end else if (d == fcs_pkg::CODE_UNLOCK1 && is_unlock(wr_addr, fcs_pkg::ADDR_55)) begin
            st_next.state = fcs_pkg::FCS_C4;
          end
        end
        fcs_pkg::FCS_C4: begin
          if (d == fcs_pkg::CODE_UNLOCK2 && is_unlock(wr_addr, fcs_pkg::ADDR_AA)) begin
            st_next.state = fcs_pkg::FCS_C5;
          end
        end
        fcs_pkg::FCS_C5: begin
          if (st_reg.third == fcs_pkg::CODE_ERASE && d == fcs_pkg::CODE_CHIP
              && is_unlock(wr_addr, fcs_pkg::ADDR_55)) begin
            if (st_reg.prot != 4'hF) begin
              st_next.state = fcs_pkg::FCS_BUSY;
              st_next.op = fcs_pkg::OP_CHIP;
              opif.start = 1'b1;
            end // all protected: back to read
          end else if (st_reg.third == fcs_pkg::CODE_ERASE && d == fcs_pkg::CODE_BLOCK) begin
            st_next.blk = blk_of(wr_addr);
            if (!st_reg.prot[blk_of(wr_addr)]) begin
              st_next.state = fcs_pkg::FCS_BUSY;
              st_next.op = fcs_pkg::OP_BLOCK;
              opif.start = 1'b1;
            end
          end else if (st_reg.third != fcs_pkg::CODE_ERASE && d == st_reg.third
                       && is_unlock(wr_addr, fcs_pkg::ADDR_55)) begin
            st_next.state = fcs_pkg::FCS_C6;
          end
        end
        fcs_pkg::FCS_C6: begin
          if (d == st_reg.third && st_reg.third == fcs_pkg::CODE_PBPROG
              && wr_addr[fcs_pkg::PB_ZERO_MSB:fcs_pkg::PB_ZERO_LSB] == 6'h00) begin
            st_next.state = fcs_pkg::FCS_BUSY;
            st_next.op = fcs_pkg::OP_PBPROG;
            st_next.blk = wr_addr[fcs_pkg::PB_SEL_MSB:fcs_pkg::PB_SEL_LSB];
            opif.start = 1'b1;
          end else if (d == st_reg.third && st_reg.third == fcs_pkg::CODE_PBERASE) begin
            st_next.state = fcs_pkg::FCS_BUSY;
            st_next.op = secured ? fcs_pkg::OP_SECERASE : fcs_pkg::OP_PBERASE;
            opif.start = 1'b1;
          end
        end
        fcs_pkg::FCS_PAGE: begin
          st_next.state = fcs_pkg::FCS_PAGE;
          if (st_reg.wcnt == '0) begin
            st_next.pbase = wr_addr[WAW+1:2];
            st_next.blk = blk_of(wr_addr);
          end
          st_next.wcnt = st_reg.wcnt + PWW'(1);
          if (st_reg.wcnt == PWW'(PAGE_WORDS - 1)) begin
            st_next.state = fcs_pkg::FCS_BUSY;
            st_next.op = fcs_pkg::OP_PAGE;
            opif.start = 1'b1;
          end
        end
        default: st_next.state = fcs_pkg::FCS_READ;
      endcase
    end
    // read path: array, identification code, or zero while busy
    if (st_reg.state == fcs_pkg::FCS_ID) begin
      unique case (st_reg.id_sel)
        fcs_pkg::ID_SEL_MAKER: st_next.rdata = {24'h000000, MAKER_CODE};
        fcs_pkg::ID_SEL_DEVICE: st_next.rdata = {24'h000000, DEVICE_CODE};
        fcs_pkg::ID_SEL_MACRO: st_next.rdata = {24'h000000, MACRO_CODE};
        default: st_next.rdata = 32'h00000000;
      endcase
    end else if (st_reg.state == fcs_pkg::FCS_BUSY) begin
      st_next.rdata = 32'h00000000;
    end else begin
      st_next.rdata = mem[rd_addr[WAW+1:2]];
    end
    if (!rd_en) begin
      st_next.rdata = st_reg.rdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{state: fcs_pkg::FCS_READ, op: fcs_pkg::OP_NONE, prot: fcs_pkg::PROT_RESET,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // array model: page words are banked on the fly, applied after the count
  logic [31:0] pbuf [PAGE_WORDS];
  always_ff @(posedge clock) begin
    if (st_reg.state == fcs_pkg::FCS_PAGE && wr_en) begin
      pbuf[st_reg.wcnt] <= wr_data;
    end
    if (opif.done) begin // results land unverified, no read-back pass
      for (int i = 0; i < WORDS; i++) begin
        if ((st_reg.op == fcs_pkg::OP_CHIP && !st_reg.prot[blk_of(32'(i) << 2)])
            || (st_reg.op == fcs_pkg::OP_BLOCK && blk_of(32'(i) << 2) == st_reg.blk)
            || st_reg.op == fcs_pkg::OP_SECERASE) begin
          mem[i] <= fcs_pkg::ERASED_WORD;
        end
      end
      if (st_reg.op == fcs_pkg::OP_PAGE && !st_reg.prot[st_reg.blk]) begin
        for (int j = 0; j < PAGE_WORDS; j++) begin
          mem[WAW'(st_reg.pbase + WAW'(j))] <= mem[WAW'(st_reg.pbase + WAW'(j))] & pbuf[j];
        end
      end
    end
  end

  assign ready_busy_flag = (st_reg.state != fcs_pkg::FCS_BUSY);
  assign protect_bits = st_reg.prot;
  assign rd_data = st_reg.rdata;

  property p_busy_flag;
    @(posedge clock) disable iff (sys_rst)
    opif.start |=> !ready_busy_flag;
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("busy flag not low after start");

  property p_ready_after;
    @(posedge clock) disable iff (sys_rst)
    opif.done |=> ready_busy_flag && st_reg.state == fcs_pkg::FCS_READ;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("not ready after operation");

  property p_ignore_busy;
    @(posedge clock) disable iff (sys_rst)
    !ready_busy_flag && !opif.done |=> !ready_busy_flag;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("busy left without done");

  property p_read_cmd;
    @(posedge clock) disable iff (sys_rst)
    wr_en && d == fcs_pkg::CODE_READ && ready_busy_flag && st_reg.state != fcs_pkg::FCS_PAGE
      |=> st_reg.state == fcs_pkg::FCS_READ;
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read command did not return to read");

  property p_all_prot;
    @(posedge clock) disable iff (sys_rst)
    st_reg.prot == 4'hF |-> !(opif.start && st_next.op == fcs_pkg::OP_CHIP);
  endproperty
  a_all_prot: assert property (p_all_prot) else $error("chip erase with all blocks protected");

  property p_prot_block;
    @(posedge clock) disable iff (sys_rst)
    opif.start && st_next.op == fcs_pkg::OP_BLOCK |-> !st_reg.prot[st_next.blk];
  endproperty
  a_prot_block: assert property (p_prot_block) else $error("protected block erase started");

  property p_pb_set;
    @(posedge clock) disable iff (sys_rst)
    opif.done && st_reg.op == fcs_pkg::OP_PBPROG |=> protect_bits[$past(st_reg.blk)];
  endproperty
  a_pb_set: assert property (p_pb_set) else $error("protect bit not set");

  property p_pb_clear;
    @(posedge clock) disable iff (sys_rst)
    opif.done && st_reg.op == fcs_pkg::OP_PBERASE |=> protect_bits == 4'h0;
  endproperty
  a_pb_clear: assert property (p_pb_clear) else $error("protect bits not cleared");

  property p_id_hold;
    @(posedge clock) disable iff (sys_rst)
    st_reg.state == fcs_pkg::FCS_ID && !(wr_en && d == fcs_pkg::CODE_READ) && !(wr_en && d != fcs_pkg::CODE_IDSEL
      && d != fcs_pkg::CODE_UNLOCK1) |=> st_reg.state == fcs_pkg::FCS_ID;
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("left ID mode without read");

  property p_sec_clear;
    @(posedge clock) disable iff (sys_rst)
    opif.done && st_reg.op == fcs_pkg::OP_SECERASE |=> protect_bits == 4'h0;
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("secured erase left protects set");

  property p_page_start;
    @(posedge clock) disable iff (sys_rst)
    wr_en && st_reg.state == fcs_pkg::FCS_PAGE && st_reg.wcnt == PWW'(PAGE_WORDS - 1) |=> !ready_busy_flag;
  endproperty
  a_page_start: assert property (p_page_start) else $error("last page word did not start program");

  property p_busy_read;
    @(posedge clock) disable iff (sys_rst)
    rd_en && st_reg.state == fcs_pkg::FCS_BUSY |=> rd_data == 32'h00000000;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("array data read while busy");

  property p_id_maker;
    @(posedge clock) disable iff (sys_rst)
    st_reg.state == fcs_pkg::FCS_ID && rd_en && st_reg.id_sel == fcs_pkg::ID_SEL_MAKER
      |=> rd_data == {24'h000000, MAKER_CODE};
  endproperty
  a_id_maker: assert property (p_id_maker) else $error("maker code not returned");

  c_page: cover property (@(posedge clock) opif.start && st_next.op == fcs_pkg::OP_PAGE);
  c_chip: cover property (@(posedge clock) opif.start && st_next.op == fcs_pkg::OP_CHIP);
  c_id: cover property (@(posedge clock) st_reg.state == fcs_pkg::FCS_ID && rd_en);
  c_block: cover property (@(posedge clock) opif.start && st_next.op == fcs_pkg::OP_BLOCK);
  c_secure: cover property (@(posedge clock) opif.start && st_next.op == fcs_pkg::OP_SECERASE);
endmodule : fcs_sequencer

// [sim/fcs_cpu_model.sv]
// Purpose: processor side of the sequencer, issuing word stores and loads
// Assumes: one clock; each cycle launched just after a rising edge
// Notes: released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
module fcs_cpu_model #(
  parameter int PAGE_WORDS = 4,
  parameter int SETTLE_CYCLES = 2000
) (
  input wire logic clock, // system clock
  input wire logic ready_busy_flag, // 1 when no automatic op runs
  input wire logic [31:0] rd_data, // load data
  output logic wr_en, // store strobe
  output logic [31:0] wr_addr, // store byte address
  output logic [31:0] wr_data, // store data
  output logic rd_en, // load request
  output logic [31:0] rd_addr // load byte address
);
  int n_late = 0;

  initial begin
    wr_en = 1'b0;
    wr_addr = 32'h00000000;
    wr_data = 32'h00000000;
    rd_en = 1'b0;
    rd_addr = 32'h00000000;
  end

  // one full word store, low address bits kept clear
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= {a[31:2], 2'h0};
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask : wr

  // load: data is taken one cycle after the request edge
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    @(posedge clock);
    #1;
    d = rd_data;
  endtask : rd

  task automatic unlock(input logic [31:0] c3);
    wr(32'h0000AA00, {24'h000000, fcs_pkg::CODE_UNLOCK1});
    wr(32'h00005400, {24'h000000, fcs_pkg::CODE_UNLOCK2});
    wr(32'h0000AA00, c3);
  endtask : unlock

  // first five cycles shared by erase and protect commands
  task automatic pre5(input logic [7:0] c3);
    unlock({24'h000000, c3});
    wr(32'h0000AA00, {24'h000000, fcs_pkg::CODE_UNLOCK1});
    wr(32'h00005400, {24'h000000, fcs_pkg::CODE_UNLOCK2});
  endtask : pre5

  // whole page from its base; caller pads unwritten words with ones
  task automatic page(input logic [31:0] base, input logic [31:0] d [PAGE_WORDS]);
    unlock({24'h000000, fcs_pkg::CODE_PROG});
    for (int i = 0; i < PAGE_WORDS; i++) begin
      wr(base + 32'(4 * i), d[i]);
    end
  endtask : page

  // wait for ready, then keep off the array for the settle time
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock);
    #1;
    while (ready_busy_flag !== 1'b1 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    // a wait that runs out is counted against the run
    if (ready_busy_flag !== 1'b1) begin
      n_late++;
    end
    repeat (SETTLE_CYCLES) @(posedge clock);
  endtask : wait_ready
endmodule : fcs_cpu_model

// [sim/flash_command_sequencer_tb.sv]
// Purpose: self-checking bench for the flash command sequencer
// Assumes: default page and block sizes, short operation time
// Notes: array is unknown after reset, so a chip erase runs first
`timescale 1ns/1ps
module flash_command_sequencer_tb;
  localparam logic [31:0] ONES = fcs_pkg::ERASED_WORD;
  localparam logic [31:0] A55 = 32'h0000AA00;
  logic clock;
  logic sys_rst;
  logic security_enable_bit;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic ready_busy_flag;
  logic [3:0] protect_bits;
  logic saw_busy;
  logic [31:0] v;
  int n_fail;
  int checks_done;
  int cycles;

  fcs_sequencer #(.OP_CYCLES(16), .MAKER_CODE(8'hC1), .DEVICE_CODE(8'hC2), .MACRO_CODE(8'hC3)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .security_enable_bit(security_enable_bit),
    .ready_busy_flag(ready_busy_flag), .protect_bits(protect_bits));
  fcs_cpu_model cpu_u (.clock(clock), .ready_busy_flag(ready_busy_flag), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (ready_busy_flag !== 1'b1) begin
      saw_busy <= 1'b1;
    end
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] c8(input logic [7:0] c);
    return {24'h000000, c};
  endfunction : c8

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    cpu_u.rd(a, v);
    check(v, exp, what);
  endtask : rdchk

  task automatic erase6(input logic [7:0] c, input logic [31:0] a);
    cpu_u.pre5(fcs_pkg::CODE_ERASE);
    cpu_u.wr(a, c8(c));
  endtask : erase6

  task automatic prot(input logic [7:0] c, input logic [1:0] blk);
    cpu_u.pre5(c);
    cpu_u.wr(A55, c8(c));
    cpu_u.wr({23'h0, blk, 7'h00}, c8(c));
    cpu_u.wait_ready();
  endtask : prot

  task automatic t_reset();
    check({31'h0, ready_busy_flag}, 32'h1, "ready after reset");
    check({28'h0, protect_bits}, 32'h0, "protects after reset");
    check(rd_data, 32'h0, "read data after reset");
    $display("done: reset");
  endtask : t_reset

  task automatic t_chip();
    erase6(fcs_pkg::CODE_CHIP, A55);
    @(posedge clock);
    #1;
    check({31'h0, ready_busy_flag}, 32'h0, "busy in chip erase");
    cpu_u.pre5(fcs_pkg::CODE_PBPROG);
    cpu_u.wr(A55, c8(fcs_pkg::CODE_PBPROG));
    cpu_u.wr(32'h00000180, c8(fcs_pkg::CODE_PBPROG));
    cpu_u.wait_ready();
    check({31'h0, ready_busy_flag}, 32'h1, "ready after erase");
    check({28'h0, protect_bits}, 32'h0, "command while busy");
    rdchk(32'h00000000, ONES, "erased first");
    rdchk(32'h0000007C, ONES, "erased last");
    $display("done: chip erase");
  endtask : t_chip

  task automatic t_page();
    cpu_u.page(32'h00000010, '{32'hA5A50F0F, 32'h000000F0, ONES, 32'h12345678});
    cpu_u.wait_ready();
    rdchk(32'h00000010, 32'hA5A50F0F, "page word 0");
    rdchk(32'h00000014, 32'h000000F0, "page word f0");
    rdchk(32'h00000018, ONES, "padded word");
    rdchk(32'h0000001C, 32'h12345678, "page word 3");
    rdchk(32'h00000020, ONES, "next page untouched");
    $display("done: page program");
  endtask : t_page

  task automatic t_protect();
    cpu_u.page(32'h00000040, '{32'h0000AAAA, ONES, ONES, ONES});
    cpu_u.wait_ready();
    prot(fcs_pkg::CODE_PBPROG, 2'h2);
    check({28'h0, protect_bits}, 32'h4, "protect block 2");
    cpu_u.page(32'h00000050, '{32'h0, 32'h0, 32'h0, 32'h0});
    cpu_u.wait_ready();
    rdchk(32'h00000050, ONES, "protected page");
    erase6(fcs_pkg::CODE_BLOCK, 32'h00000044);
    cpu_u.wait_ready();
    rdchk(32'h00000040, 32'h0000AAAA, "protected block erase");
    erase6(fcs_pkg::CODE_CHIP, A55);
    cpu_u.wait_ready();
    rdchk(32'h00000010, ONES, "chip erase open block");
    rdchk(32'h00000040, 32'h0000AAAA, "chip erase skips");
    cpu_u.page(32'h00000000, '{32'h11110000, ONES, ONES, ONES});
    cpu_u.wait_ready();
    erase6(fcs_pkg::CODE_BLOCK, 32'h00000008);
    cpu_u.wait_ready();
    rdchk(32'h00000000, ONES, "block erase");
    rdchk(32'h00000040, 32'h0000AAAA, "other block kept");
    $display("done: protection");
  endtask : t_protect

  task automatic t_secure();
    prot(fcs_pkg::CODE_PBPROG, 2'h0);
    prot(fcs_pkg::CODE_PBPROG, 2'h1);
    prot(fcs_pkg::CODE_PBPROG, 2'h3);
    check({28'h0, protect_bits}, 32'hF, "all protected");
    saw_busy = 1'b0;
    erase6(fcs_pkg::CODE_CHIP, A55);
    repeat (30) @(posedge clock);
    check({31'h0, saw_busy}, 32'h0, "no erase when all protected");
    rdchk(32'h00000040, 32'h0000AAAA, "data kept");
    prot(fcs_pkg::CODE_PBERASE, 2'h0);
    check({28'h0, protect_bits}, 32'h0, "protect erase");
    rdchk(32'h00000040, 32'h0000AAAA, "open erase keeps data");
    for (int b = 0; b < 4; b++) begin
      prot(fcs_pkg::CODE_PBPROG, 2'(b));
    end
    security_enable_bit <= 1'b1;
    prot(fcs_pkg::CODE_PBERASE, 2'h0);
    check({28'h0, protect_bits}, 32'h0, "secured protect erase");
    rdchk(32'h00000040, ONES, "secured erase clears array");
    security_enable_bit <= 1'b0;
    $display("done: security");
  endtask : t_secure

  task automatic t_id();
    logic [7:0] exp [4];
    exp = '{8'hC1, 8'hC2, 8'h00, 8'hC3};
    cpu_u.unlock(32'h12345690);
    for (int s = 0; s < 4; s++) begin
      cpu_u.wr({18'h0, 2'(s), 12'h000}, c8(fcs_pkg::CODE_IDSEL));
      cpu_u.rd(32'h00000040, v);
      check({24'h0, v[7:0]}, c8(exp[s]), "code value");
    end
    cpu_u.wr(32'h00000000, c8(fcs_pkg::CODE_READ));
    rdchk(32'h00000040, ONES, "read command");
    cpu_u.unlock(c8(fcs_pkg::CODE_IDREAD));
    cpu_u.wr(32'h00001000, c8(fcs_pkg::CODE_IDSEL));
    cpu_u.unlock(c8(fcs_pkg::CODE_READ));
    rdchk(32'h00000040, ONES, "read reset");
    $display("done: identification");
  endtask : t_id

  task automatic t_abort();
    saw_busy = 1'b0;
    cpu_u.wr(A55, c8(fcs_pkg::CODE_UNLOCK1));
    cpu_u.wr(A55, c8(fcs_pkg::CODE_UNLOCK2));
    cpu_u.wr(32'h00005400, c8(fcs_pkg::CODE_UNLOCK2));
    cpu_u.wr(A55, c8(fcs_pkg::CODE_ERASE));
    cpu_u.unlock(c8(fcs_pkg::CODE_CHIP));
    cpu_u.unlock(c8(fcs_pkg::CODE_ERASE));
    cpu_u.wr(32'h00000000, c8(fcs_pkg::CODE_READ));
    cpu_u.wr(A55, c8(fcs_pkg::CODE_CHIP));
    repeat (30) @(posedge clock);
    check({31'h0, saw_busy}, 32'h0, "abandoned sequences");
    $display("done: abort");
  endtask : t_abort

  task automatic stop_test();
    n_fail = n_fail + cpu_u.n_late;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    sys_rst = 1'b1;
    security_enable_bit = 1'b0;
    saw_busy = 1'b0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_chip();
    t_page();
    t_protect();
    t_abort();
    t_secure();
    t_id();
    stop_test();
  end
endmodule : flash_command_sequencer_tb
